// file: logic/avs_cmd_handler.v
// Holds the AVSBus slave command handler of a two-channel regulator controller.
// Assumes the host drives avs_clk and avs_mdata, telemetry and warnings come from logic on clk.
`timescale 1ns/100ps
`include "avs_cmd_map.vh"

module avs_cmd_handler (
    input  wire        clk,             // System clock, 40 MHz.
    input  wire        rst,             // Synchronous reset, active high.
    input  wire        avs_clk,         // Bus clock from the host, asynchronous.
    input  wire        avs_mdata,       // Master data line, asynchronous.
    output reg         avs_sdata,       // Slave data line.
    input  wire [15:0] pmbus_slew_a,    // PMBus slew default, channel A.
    input  wire [15:0] pmbus_slew_b,    // PMBus slew default, channel B.
    input  wire [15:0] iout_a,          // Measured current, channel A, 10 mA steps.
    input  wire [15:0] iout_b,          // Measured current, channel B, 10 mA steps.
    input  wire [15:0] temp_a,          // Stage temperature, channel A, signed 0.1 C.
    input  wire [15:0] temp_b,          // Stage temperature, channel B, signed 0.1 C.
    input  wire [15:0] boot_voltage_a,  // Boot voltage from pin strap, channel A.
    input  wire [15:0] boot_voltage_b,  // Boot voltage from stored settings, channel B.
    input  wire [15:0] warn_event,      // Warning set pulses, one bit per status bit.
    input  wire        vout_settled,    // Output has reached its target.
    input  wire        reset_pin_low,   // Reset pin function is asserted.
    output wire [15:0] slew_rise_a,     // Applied rising rate A, 1/256 mV/us.
    output wire [15:0] slew_fall_a,     // Applied falling rate A, 1/256 mV/us.
    output wire [15:0] slew_rise_b,     // Applied rising rate B, 1/256 mV/us.
    output wire [15:0] slew_fall_b,     // Applied falling rate B, 1/256 mV/us.
    output reg  [15:0] boot_target_a,   // Target taken on return to boot, channel A.
    output reg  [15:0] boot_target_b,   // Target taken on return to boot, channel B.
    output reg         boot_load_a,     // One-cycle pulse: channel A returns to boot.
    output reg         boot_load_b,     // One-cycle pulse: channel B returns to boot.
    output reg         avs_control      // AVSBus has taken control of the output.
);

    // --------------------------------------------------------------------
    // States
    // --------------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_RECV = 4'h2;
    localparam [3:0] ST_EXEC = 4'h4;
    localparam [3:0] ST_SEND = 4'h8;

    // --------------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------------
    // Two stages on each pin; the edge detector looks only at the second stage onward.
    reg  [1:0] clk_sync;
    reg  [1:0] md_sync;
    reg        clk_last;
    always @(posedge clk) begin
        if (rst) begin
            clk_sync <= 2'h0;
            md_sync  <= 2'h3;
            clk_last <= 1'b0;
        end else begin
            clk_sync <= {clk_sync[0], avs_clk};
            md_sync  <= {md_sync[0], avs_mdata};
            clk_last <= clk_sync[1];
        end
    end
    wire bus_rise = clk_sync[1] & ~clk_last;
    wire md_bit   = md_sync[1];

    // --------------------------------------------------------------------
    // Frame fields
    // --------------------------------------------------------------------
    reg  [3:0]  state;
    reg  [5:0]  bit_cnt;
    reg  [31:0] rx;
    reg  [31:0] tx;
    wire [2:0]  rx_crc;
    wire [2:0]  tx_crc;

    wire [1:0]  f_start = rx[`MF_START_HI:`MF_START_LO];
    wire [1:0]  f_acc   = rx[`MF_CMD_HI:`MF_CMD_LO];
    wire        f_grp   = rx[`MF_GROUP];
    wire [3:0]  f_type  = rx[`MF_TYPE_HI:`MF_TYPE_LO];
    wire [3:0]  f_sel   = rx[`MF_SEL_HI:`MF_SEL_LO];
    wire [15:0] f_data  = rx[`MF_DATA_HI:`MF_DATA_LO];

    avs_crc3 u_rx_crc (
        .frame_bits (rx[31:3]),
        .crc        (rx_crc)
    );

    // Select decode; any code other than A, B or both is refused.
    wire is_read  = (f_acc == `ACC_READ);
    wire is_write = (f_acc == `ACC_WRITE) | (f_acc == `ACC_WRITE_HOLD);
    wire sel_ch   = (f_sel == `SEL_A) | (f_sel == `SEL_B);
    wire sel_all  = (f_sel == `SEL_ALL);
    wire [1:0] hit = sel_all ? 2'h3 : {f_sel == `SEL_B, f_sel == `SEL_A};
    wire crc_ok   = (rx_crc == rx[2:0]) & (f_start == `START_CODE);

    // --------------------------------------------------------------------
    // Stored state
    // --------------------------------------------------------------------
    reg  [15:0] pmode;
    reg  [15:0] status;
    reg  [1:0]  avs_owned;
    wire [31:0] set_bus;

    // --------------------------------------------------------------------
    // Command decode
    // --------------------------------------------------------------------
    // Reads may never broadcast except status and version; writes may target both channels.
    reg        cmd_ok;
    reg [15:0] rdata;
    always @* begin
        cmd_ok = 1'b0;
        rdata  = `DATA_FILL;
        case (f_type)
            `T_SLEW: begin
                cmd_ok = is_read ? sel_ch : (is_write & (sel_ch | sel_all));
                rdata  = f_sel[0] ? set_bus[31:16] : set_bus[15:0];
            end
            `T_IOUT: begin
                cmd_ok = is_read & sel_ch;
                rdata  = {1'b0, f_sel[0] ? iout_b[14:0] : iout_a[14:0]};
            end
            `T_TEMP: begin
                cmd_ok = is_read & sel_ch;
                rdata  = f_sel[0] ? temp_b : temp_a;
            end
            `T_BOOT: begin
                cmd_ok = is_write & (sel_ch | sel_all) & (f_data == 16'h0000);
            end
            `T_PMODE: begin
                cmd_ok = is_read ? sel_ch : (is_write & (sel_ch | sel_all));
                rdata  = pmode;
            end
            `T_STATUS: begin
                cmd_ok = (is_read | is_write) & (sel_ch | sel_all);
                rdata  = status;
            end
            `T_VERSION: begin
                cmd_ok = is_read & sel_all;
                rdata  = `VERSION_VALUE;
            end
            default: begin
                cmd_ok = 1'b0;
                rdata  = `DATA_FILL;
            end
        endcase
    end

    // Bad check wins over bad content; a refused frame takes no action.
    wire [1:0] ack = !crc_ok ? `ACK_BAD_CRC :
                     (!cmd_ok | f_grp) ? `ACK_INVALID : `ACK_GOOD;
    wire act       = (state == ST_EXEC) & (ack == `ACK_GOOD);
    wire wr_act    = act & is_write;

    // Slave frame: write answers carry the fill pattern in the data field.
    wire [4:0]  summary = {vout_settled, |status, avs_control, reset_pin_low, 1'b0};
    wire [15:0] sdata_word = (ack == `ACK_GOOD) & is_read ? rdata : `DATA_FILL;
    wire [28:0] tx_head = {ack, 1'b0, summary, sdata_word, `SLAVE_FILL};

    avs_crc3 u_tx_crc (
        .frame_bits (tx_head),
        .crc        (tx_crc)
    );

    // --------------------------------------------------------------------
    // Frame sequencer
    // --------------------------------------------------------------------
    // The answer follows the master frame in the next 32 bus clocks; it changes on the rising edge.
    always @(posedge clk) begin
        if (rst) begin
            state     <= ST_IDLE;
            bit_cnt   <= 6'h00;
            rx        <= 32'h0000_0000;
            tx        <= 32'h0000_0000;
            avs_sdata <= 1'b1;
        end else begin
            case (state)
                ST_IDLE: begin
                    avs_sdata <= ~(|status);
                    if (bus_rise & ~md_bit) begin
                        rx      <= {31'h0000_0000, md_bit};
                        bit_cnt <= 6'h01;
                        state   <= ST_RECV;
                    end
                end
                ST_RECV: begin
                    if (bus_rise) begin
                        rx      <= {rx[30:0], md_bit};
                        bit_cnt <= bit_cnt + 6'h01;
                        if (bit_cnt == `FRAME_BITS - 6'h01) begin
                            state <= ST_EXEC;
                        end
                    end
                end
                ST_EXEC: begin
                    tx      <= {tx_head, tx_crc};
                    bit_cnt <= 6'h00;
                    state   <= ST_SEND;
                end
                ST_SEND: begin
                    if (bus_rise) begin
                        if (bit_cnt == `FRAME_BITS) begin
                            avs_sdata <= ~(|status);
                            state     <= ST_IDLE;
                        end else begin
                            avs_sdata <= tx[31];
                            tx        <= {tx[30:0], 1'b0};
                            bit_cnt   <= bit_cnt + 6'h01;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // --------------------------------------------------------------------
    // Status word, power mode and bus control
    // --------------------------------------------------------------------
    // A warning arriving in the clearing cycle stays set, so no event is lost.
    wire [15:0] clear_bits = (wr_act & (f_type == `T_STATUS)) ? f_data : 16'h0000;
    wire [15:0] next_status = (status & ~clear_bits) | (warn_event & `STATUS_MASK);
    always @(posedge clk) begin
        if (rst) begin
            status      <= `STATUS_RESET;
            pmode       <= `PMODE_RESET;
            avs_control <= 1'b0;
        end else begin
            status <= next_status;
            if (wr_act & (f_type == `T_PMODE)) begin
                pmode <= f_data;
            end
            if (wr_act & (f_type != `T_STATUS)) begin
                avs_control <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------------------
    // Return to boot voltage
    // --------------------------------------------------------------------
    wire boot_go = wr_act & (f_type == `T_BOOT);
    always @(posedge clk) begin
        if (rst) begin
            boot_target_a <= 16'h0000;
            boot_target_b <= 16'h0000;
            boot_load_a   <= 1'b0;
            boot_load_b   <= 1'b0;
        end else begin
            boot_load_a <= boot_go & hit[0];
            boot_load_b <= boot_go & hit[1];
            if (boot_go & hit[0]) begin
                boot_target_a <= boot_voltage_a;
            end
            if (boot_go & hit[1]) begin
                boot_target_b <= boot_voltage_b;
            end
        end
    end

    // --------------------------------------------------------------------
    // Slew settings per channel
    // --------------------------------------------------------------------
    // Out-of-range bytes are pulled to the nearest limit rather than refused.
    function [7:0] clamp_rate;
        input [7:0] v;
        begin
            if (v < `SLEW_MIN) begin
                clamp_rate = `SLEW_MIN;
            end else if (v > `SLEW_MAX) begin
                clamp_rate = `SLEW_MAX;
            end else begin
                clamp_rate = v;
            end
        end
    endfunction

    wire        slew_go = wr_act & (f_type == `T_SLEW);
    wire [31:0] pm_bus  = {pmbus_slew_b, pmbus_slew_a};
    wire [63:0] out_bus;

    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1) begin : gen_ch
            reg  [7:0]  rise_set;
            reg  [7:0]  fall_set;
            reg  [15:0] rise_out;
            reg  [15:0] fall_out;
            reg         owned;
            // Settings; the two bytes live in separate registers.
            always @(posedge clk) begin
                if (rst) begin
                    rise_set <= pm_bus[c*16+8 +: 8];
                    fall_set <= pm_bus[c*16 +: 8];
                    owned    <= 1'b0;
                end else if (slew_go & hit[c]) begin
                    rise_set <= clamp_rate(f_data[15:8]);
                    fall_set <= clamp_rate(f_data[7:0]);
                    owned    <= 1'b1;
                end
            end
            // Applied rates; the AVSBus path is scaled down, the PMBus path is not.
            always @(posedge clk) begin
                if (rst) begin
                    rise_out <= 16'h0000;
                    fall_out <= 16'h0000;
                end else if (owned) begin
                    rise_out <= {8'h00, rise_set} * `AVS_SLEW_SCALE;
                    fall_out <= {8'h00, fall_set} * `AVS_SLEW_SCALE;
                end else begin
                    rise_out <= {rise_set, 8'h00};
                    fall_out <= {fall_set, 8'h00};
                end
            end
            assign set_bus[c*16 +: 16] = {rise_set, fall_set};
            assign out_bus[c*32 +: 32] = {rise_out, fall_out};
            always @(posedge clk) begin
                if (rst) begin
                    avs_owned[c] <= 1'b0;
                end else begin
                    avs_owned[c] <= owned;
                end
            end
        end
    endgenerate

    // Per-channel outputs.
    assign slew_fall_a = out_bus[15:0];
    assign slew_rise_a = out_bus[31:16];
    assign slew_fall_b = out_bus[47:32];
    assign slew_rise_b = out_bus[63:48];

endmodule

// file: logic/avs_cmd_map.vh
// Holds the constants of the AVSBus command handler: frame fields, command codes, select codes,
// acknowledge codes, register reset values and slew limits.
// Assumes it is included by its bare name from every file of the handler.
`ifndef AVS_CMD_MAP_VH
`define AVS_CMD_MAP_VH

// Frame length and field positions of the master frame, in bits.
`define FRAME_BITS      6'd32
`define MF_START_HI     31
`define MF_START_LO     30
`define MF_CMD_HI       29
`define MF_CMD_LO       28
`define MF_GROUP        27
`define MF_TYPE_HI      26
`define MF_TYPE_LO      23
`define MF_SEL_HI       22
`define MF_SEL_LO       19
`define MF_DATA_HI      18
`define MF_DATA_LO      3
`define START_CODE      2'h1
`define CRC_INIT        3'h0

// Access codes carried in the command field.
`define ACC_WRITE       2'h0
`define ACC_WRITE_HOLD  2'h1
`define ACC_READ        2'h3

// Command types, which double as the register offsets.
`define T_SLEW          4'h1
`define T_IOUT          4'h2
`define T_TEMP          4'h3
`define T_BOOT          4'h4
`define T_PMODE         4'h5
`define T_STATUS        4'hE
`define T_VERSION       4'hF

// Select codes.
`define SEL_A           4'h0
`define SEL_B           4'h1
`define SEL_ALL         4'hF

// Acknowledge codes.
`define ACK_GOOD        2'h0
`define ACK_BAD_CRC     2'h2
`define ACK_INVALID     2'h3

// Register reset values, masks and fill patterns.
`define PMODE_RESET     16'h0000
`define STATUS_RESET    16'h0000
`define STATUS_MASK     16'hF0FE
`define VERSION_VALUE   16'h0000
`define DATA_FILL       16'hFFFF
`define SLAVE_FILL      5'h1F

// Slew limits in mV/us and the AVSBus scale factor in 1/256 steps (about -5 percent).
`define SLEW_MIN        8'h01
`define SLEW_MAX        8'h28
`define AVS_SLEW_SCALE  16'h00F3

`endif

// file: logic/avs_crc3.v
// Holds the 3-bit frame check used on both AVSBus data lines, polynomial x^3 + x + 1.
// Assumes the 29 bits ahead of the check field are presented MSB first, all in one cycle.
`timescale 1ns/100ps
`include "avs_cmd_map.vh"

module avs_crc3 (
    input  wire [28:0] frame_bits,   // Bits 31 down to 3 of a frame.
    output reg  [2:0]  crc           // Check value for those bits.
);

    // --------------------------------------------------------------------
    // Serial divider unrolled by a loop
    // --------------------------------------------------------------------
    // A loop keeps the check identical for the master and the slave frame.
    integer i;
    reg     fb;
    always @* begin
        crc = `CRC_INIT;
        fb  = 1'b0;
        for (i = 28; i >= 0; i = i - 1) begin
            fb  = crc[2] ^ frame_bits[i];
            crc = {crc[1], crc[0] ^ fb, fb};
        end
    end

endmodule

// file: verification/avs_cmd_handler_monitor.sv
// Checker for the AVSBus command handler: slew defaults, applied rates and boot loads.
// Assumes the bench holds the PMBus defaults and boot voltages constant.
`timescale 1ns/100ps

module avs_cmd_handler_monitor (
    input wire        clk,            // Clock.
    input wire        rst,            // Reset.
    input wire [15:0] pmbus_slew_a,   // Default A.
    input wire [15:0] pmbus_slew_b,   // Default B.
    input wire [15:0] boot_voltage_a, // Boot A.
    input wire [15:0] boot_voltage_b, // Boot B.
    input wire [15:0] slew_rise_a,    // Rise A.
    input wire [15:0] slew_fall_a,    // Fall A.
    input wire [15:0] slew_rise_b,    // Rise B.
    input wire [15:0] slew_fall_b,    // Fall B.
    input wire [15:0] boot_target_a,  // Target A.
    input wire [15:0] boot_target_b,  // Target B.
    input wire        boot_load_a,    // Load A.
    input wire        boot_load_b     // Load B.
);
    // All checks share the system clock, and reset silences them.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_reset_slew_a;
        $fell(rst) |=> slew_rise_a == {pmbus_slew_a[15:8], 8'h00} && slew_fall_a == {pmbus_slew_a[7:0], 8'h00};
    endproperty
    a_reset_slew_a: assert property (p_reset_slew_a) else $error("slew A not loaded from default");
    property p_reset_slew_b;
        $fell(rst) |=> slew_rise_b == {pmbus_slew_b[15:8], 8'h00} && slew_fall_b == {pmbus_slew_b[7:0], 8'h00};
    endproperty
    a_reset_slew_b: assert property (p_reset_slew_b) else $error("slew B not loaded from default");
    // Past the reset load, rise A and fall B move only to a clamped setting times 243/256.
    property p_rate_rise_a;
        $changed(slew_rise_a) && !$past(rst, 2) |-> slew_rise_a % 16'd243 == 0 && slew_rise_a inside {[243:9720]};
    endproperty
    a_rate_rise_a: assert property (p_rate_rise_a) else $error("rise A not a scaled clamped rate");
    property p_rate_fall_b;
        $changed(slew_fall_b) && !$past(rst, 2) |-> slew_fall_b % 16'd243 == 0 && slew_fall_b inside {[243:9720]};
    endproperty
    a_rate_fall_b: assert property (p_rate_fall_b) else $error("fall B not a scaled clamped rate");
    property p_pulse_a;
        boot_load_a |=> !boot_load_a;
    endproperty
    a_pulse_a: assert property (p_pulse_a) else $error("boot load A longer than one cycle");
    property p_pulse_b;
        boot_load_b |=> !boot_load_b [*8];
    endproperty
    a_pulse_b: assert property (p_pulse_b) else $error("boot load B repeated");
    property p_target_a;
        boot_load_a |-> ##[0:1] boot_target_a == boot_voltage_a;
    endproperty
    a_target_a: assert property (p_target_a) else $error("boot target A wrong");
    property p_target_b;
        boot_load_b |-> ##[0:1] boot_target_b == boot_voltage_b;
    endproperty
    a_target_b: assert property (p_target_b) else $error("boot target B wrong");
    property p_target_hold_a;
        $changed(boot_target_a) |-> boot_load_a || $past(boot_load_a);
    endproperty
    a_target_hold_a: assert property (p_target_hold_a) else $error("boot target A moved unasked");
endmodule

bind avs_cmd_handler avs_cmd_handler_monitor i_mon (.clk(clk), .rst(rst), .pmbus_slew_a(pmbus_slew_a),
    .pmbus_slew_b(pmbus_slew_b), .boot_voltage_a(boot_voltage_a), .boot_voltage_b(boot_voltage_b),
    .slew_rise_a(slew_rise_a), .slew_fall_a(slew_fall_a), .slew_rise_b(slew_rise_b), .slew_fall_b(slew_fall_b),
    .boot_target_a(boot_target_a), .boot_target_b(boot_target_b), .boot_load_a(boot_load_a),
    .boot_load_b(boot_load_b));

// file: verification/avs_host_model.sv
// Host bus controller model: sends one master frame, then clocks out the answer.
// Assumes one frame at a time; the bus clock stands low and data idles high between frames.
`timescale 1ns/100ps

module avs_host_model (
    output logic avs_clk,   // Bus clock, 200 ns period.
    output logic avs_mdata, // Master data.
    input  wire  avs_sdata  // Slave data.
);
    localparam int HALF = 100;

    // Three-bit frame check, x^3 + x + 1, over bits 31 down to 3.
    function automatic [2:0] crc3(input [28:0] b);
        reg [2:0] c;
        reg       fb;
        integer   i;
        c = 3'h0;
        for (i = 28; i >= 0; i--) begin
            fb = c[2] ^ b[i];
            c = {c[1], c[0] ^ fb, fb};
        end
        return c;
    endfunction

    initial begin
        avs_clk = 1'b0;
        avs_mdata = 1'b1;
    end

    // Data changes and the answer is sampled on the falling edge; a 33rd rising edge lets
    // the device return to idle.
    task automatic xfer(input [1:0] acc, input [3:0] typ, input [3:0] sel, input [15:0] dat,
                        input bad, output [31:0] resp);
        reg [31:0] f;
        integer    i;
        f[31:3] = {2'h1, acc, 1'b0, typ, sel, dat};
        f[2:0] = crc3(f[31:3]) ^ {2'h0, bad};
        for (i = 31; i >= 0; i--) begin
            avs_mdata = f[i];
            #HALF avs_clk = 1'b1;
            #HALF avs_clk = 1'b0;
        end
        avs_mdata = 1'b1;
        for (i = 31; i >= 0; i--) begin
            #HALF avs_clk = 1'b1;
            #HALF avs_clk = 1'b0;
            resp[i] = avs_sdata;
        end
        #HALF avs_clk = 1'b1;
        #HALF avs_clk = 1'b0;
    endtask
endmodule

// file: verification/avsbus_command_handler_tb_top.sv
// Testbench for the AVSBus command handler, with the host model on the bus.
// Assumes the checker is bound to the handler and frames run one after another.
`timescale 1ns/100ps
`include "avs_cmd_map.vh"

module avsbus_command_handler_tb_top;
    localparam [15:0] PM_A = 16'h0A14;
    localparam [15:0] PM_B = 16'h0305;
    localparam [15:0] BV_A = 16'h0370;
    localparam [15:0] BV_B = 16'h03E8;
    localparam [1:0]  WR   = `ACC_WRITE;
    localparam [1:0]  RD   = `ACC_READ;
    logic        clk, rst, vout_settled, reset_pin_low;
    logic [15:0] iout_a, iout_b, temp_a, temp_b, warn_event;
    wire         avs_clk, avs_mdata, avs_sdata, boot_load_a, boot_load_b, avs_control;
    wire  [15:0] slew_rise_a, slew_fall_a, slew_rise_b, slew_fall_b, boot_target_a, boot_target_b;
    logic [31:0] r;
    integer      bad_count = 0, num_checks = 0, loads_a = 0, loads_b = 0;

    avs_host_model i_host (.avs_clk(avs_clk), .avs_mdata(avs_mdata), .avs_sdata(avs_sdata));
    avs_cmd_handler i_dut (.clk(clk), .rst(rst), .avs_clk(avs_clk), .avs_mdata(avs_mdata),
        .avs_sdata(avs_sdata), .pmbus_slew_a(PM_A), .pmbus_slew_b(PM_B), .iout_a(iout_a),
        .iout_b(iout_b), .temp_a(temp_a), .temp_b(temp_b), .boot_voltage_a(BV_A),
        .boot_voltage_b(BV_B), .warn_event(warn_event), .vout_settled(vout_settled),
        .reset_pin_low(reset_pin_low), .slew_rise_a(slew_rise_a), .slew_fall_a(slew_fall_a),
        .slew_rise_b(slew_rise_b), .slew_fall_b(slew_fall_b), .boot_target_a(boot_target_a),
        .boot_target_b(boot_target_b), .boot_load_a(boot_load_a), .boot_load_b(boot_load_b),
        .avs_control(avs_control));

    // Clock, and a count of boot loads per channel.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (boot_load_a === 1'b1) loads_a++;
        if (boot_load_b === 1'b1) loads_b++;
    end

    task automatic check(input string what, input [15:0] exp, input [15:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One frame; judges the code, the data and the fixed bits and check of the answer.
    task automatic op(input [1:0] acc, input [3:0] typ, input [3:0] sel, input [15:0] dat,
                      input bad, input [1:0] ack, input [15:0] data);
        i_host.xfer(acc, typ, sel, dat, bad, r);
        check("ack", {14'h0, ack}, {14'h0, r[31:30]});
        check("data", data, r[23:8]);
        check("fixed", {8'h0, 5'h1F, i_host.crc3(r[31:3])}, {7'h0, r[29], r[7:3], r[2:0]});
    endtask

    task automatic t_reset;
        check("rise a", {PM_A[15:8], 8'h00}, slew_rise_a);
        check("fall b", {PM_B[7:0], 8'h00}, slew_fall_b);
        op(RD, `T_PMODE, `SEL_A, 16'hFFFF, 0, `ACK_GOOD, 16'h0000);
        op(RD, `T_STATUS, `SEL_ALL, 16'hFFFF, 0, `ACK_GOOD, 16'h0000);
        op(RD, `T_VERSION, `SEL_ALL, 16'hFFFF, 0, `ACK_GOOD, 16'h0000);
        op(RD, `T_VERSION, `SEL_A, 16'hFFFF, 0, `ACK_INVALID, 16'hFFFF);
        $display("test reset done");
    endtask

    task automatic t_telemetry;
        @(posedge clk);
        iout_a <= 16'h9043;
        temp_a <= 16'hFF62;
        vout_settled <= 1'b1;
        reset_pin_low <= 1'b1;
        op(RD, `T_IOUT, `SEL_A, 16'hFFFF, 0, `ACK_GOOD, 16'h1043);
        check("summary", 16'h0012, {11'h0, r[28:24]});
        op(RD, `T_IOUT, `SEL_B, 16'hFFFF, 0, `ACK_GOOD, 16'h1086);
        op(RD, `T_TEMP, `SEL_A, 16'hFFFF, 0, `ACK_GOOD, 16'hFF62);
        op(RD, `T_TEMP, `SEL_B, 16'hFFFF, 0, `ACK_GOOD, 16'h0358);
        op(RD, `T_IOUT, `SEL_ALL, 16'hFFFF, 0, `ACK_INVALID, 16'hFFFF);
        op(RD, `T_TEMP, 4'h2, 16'hFFFF, 0, `ACK_INVALID, 16'hFFFF);
        $display("test telemetry done");
    endtask

    // Applied rates are the setting times 243/256, so 10 gives 097E and 2 gives 01E6.
    task automatic t_slew;
        op(WR, `T_SLEW, `SEL_A, 16'h0A02, 0, `ACK_GOOD, 16'hFFFF);
        check("control", 16'h0001, {15'h0, avs_control});
        check("rise a", 16'h097E, slew_rise_a);
        check("fall a", 16'h01E6, slew_fall_a);
        check("rise b", {PM_B[15:8], 8'h00}, slew_rise_b);
        op(WR, `T_SLEW, `SEL_B, 16'h3200, 0, `ACK_GOOD, 16'hFFFF);
        check("rise b", 16'h25F8, slew_rise_b);
        check("fall b", 16'h00F3, slew_fall_b);
        check("fall a", 16'h01E6, slew_fall_a);
        op(RD, `T_SLEW, `SEL_B, 16'hFFFF, 0, `ACK_GOOD, 16'h2801);
        $display("test slew done");
    endtask

    task automatic t_boot;
        op(WR, `T_BOOT, `SEL_A, 16'h0001, 0, `ACK_INVALID, 16'hFFFF);
        check("no load", 16'h0000, loads_a[15:0]);
        op(WR, `T_BOOT, `SEL_ALL, 16'h0000, 0, `ACK_GOOD, 16'hFFFF);
        check("loads", 16'h0101, {loads_a[7:0], loads_b[7:0]});
        check("target a", BV_A, boot_target_a);
        check("target b", BV_B, boot_target_b);
        op(RD, `T_BOOT, `SEL_A, 16'hFFFF, 0, `ACK_INVALID, 16'hFFFF);
        $display("test boot done");
    endtask

    task automatic t_status;
        @(posedge clk);
        warn_event <= 16'h1000;
        @(posedge clk);
        warn_event <= 16'h0000;
        repeat (4) @(posedge clk);
        check("notify", 16'h0000, {15'h0, avs_sdata});
        op(RD, `T_STATUS, `SEL_A, 16'hFFFF, 0, `ACK_GOOD, 16'h1000);
        check("summary", 16'h0001, {15'h0, r[27]});
        op(WR, `T_STATUS, `SEL_ALL, 16'h0800, 0, `ACK_GOOD, 16'hFFFF);
        op(RD, `T_STATUS, `SEL_ALL, 16'hFFFF, 0, `ACK_GOOD, 16'h1000);
        op(WR, `T_STATUS, `SEL_B, 16'h1000, 0, `ACK_GOOD, 16'hFFFF);
        check("released", 16'h0001, {15'h0, avs_sdata});
        op(WR, `T_PMODE, `SEL_ALL, 16'h1234, 0, `ACK_GOOD, 16'hFFFF);
        op(WR, `T_PMODE, `SEL_A, 16'h0000, 1, `ACK_BAD_CRC, 16'hFFFF);
        op(RD, `T_PMODE, `SEL_B, 16'hFFFF, 0, `ACK_GOOD, 16'h1234);
        op(WR, `T_IOUT, `SEL_A, 16'h0000, 0, `ACK_INVALID, 16'hFFFF);
        $display("test status done");
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Some 24 frames of 13 us each; a millisecond leaves ample margin.
    initial begin
        #1000000;
        bad_count++;
        finish_test;
    end

    initial begin
        rst = 1'b1;
        {iout_a, iout_b, temp_a, temp_b, warn_event} = {16'h0, 16'h1086, 16'h0, 16'h0358, 16'h0};
        {vout_settled, reset_pin_low} = 2'b00;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset;
        t_telemetry;
        t_slew;
        t_boot;
        t_status;
        finish_test;
    end
endmodule
